// [rtl/zero_cross_detect_logic.sv]
`timescale 1ns/100ps
module zero_cross_detect_logic (
  input  wire logic CLK_SYS_IN,
  input  wire logic RSTN_IN,
  input  wire logic RAW_SINK_ACTIVE_IN,
  input  wire logic DETECT_ENABLE_IN,
  input  wire logic INVERT_SELECT_IN,
  input  wire logic RISE_IRQ_ENABLE_IN,
  input  wire logic FALL_IRQ_ENABLE_IN,
  input  wire logic ZERO_CROSS_IRQ_ENABLE_IN,
  input  wire logic PERIPHERAL_IRQ_ENABLE_IN,
  input  wire logic GLOBAL_IRQ_ENABLE_IN,
  input  wire logic FLAG_CLEAR_IN,
  output logic      ZERO_CROSS_LEVEL_SIGNAL_OUT,
  output logic      ZERO_CROSS_IRQ_FLAG_OUT,
  output logic      IRQ_OUT
);
  import zero_cross_pkg::*;

  typedef struct packed {
    logic                lvl;
    logic                invert_select;
    logic                flag;
    logic                irq;
    logic [SETTLE_W-1:0] settle;
  } det_s;

  det_s st_q;
  det_s st_d;
  logic sync_lvl;
  logic primed;
  logic adj_lvl;
  logic rise_ev;
  logic fall_ev;
  logic pol_ev;
  logic set_ev;

  // ----------------------------------------------------------------
  // input synchroniser
  // ----------------------------------------------------------------
  zero_cross_sync u_sync (
    .clk_sys_in (CLK_SYS_IN),
    .rstn_in    (RSTN_IN),
    .async_in   (RAW_SINK_ACTIVE_IN),
    .sync_out   (sync_lvl)
  );

  // ----------------------------------------------------------------
  // level, edges and flag
  // ----------------------------------------------------------------
  // edges are ignored until the synchroniser holds real samples,
  // otherwise a pin high at reset release looks like a rising edge
  assign primed  = (st_q.settle == SETTLE_CYCLES);
  assign adj_lvl = sync_lvl ^ INVERT_SELECT_IN;
  assign rise_ev = primed & DETECT_ENABLE_IN & adj_lvl & ~st_q.lvl;
  assign fall_ev = primed & DETECT_ENABLE_IN & ~adj_lvl & st_q.lvl;
  // polarity change counts even with the detector disabled
  assign pol_ev  = primed & (INVERT_SELECT_IN != st_q.invert_select);
  assign set_ev  = (rise_ev & RISE_IRQ_ENABLE_IN)
                 | (fall_ev & FALL_IRQ_ENABLE_IN)
                 | pol_ev;

  always_comb begin
    st_d     = st_q;
    st_d.lvl = adj_lvl;
    st_d.invert_select = INVERT_SELECT_IN;
    if (!primed) begin
      st_d.settle = st_q.settle + 2'h1;
    end
    // set beats clear; only FLAG_CLEAR_IN and reset clear the flag
    if (set_ev) begin
      st_d.flag = 1'b1;
    end else if (FLAG_CLEAR_IN) begin
      st_d.flag = 1'b0;
    end
    st_d.irq = st_d.flag & ZERO_CROSS_IRQ_ENABLE_IN
             & PERIPHERAL_IRQ_ENABLE_IN & GLOBAL_IRQ_ENABLE_IN;
  end

  always_ff @(posedge CLK_SYS_IN) begin
    if (!RSTN_IN) begin
      st_q.lvl    <= LEVEL_RST;
      st_q.invert_select    <= INVERT_RST;
      st_q.flag   <= FLAG_RST;
      st_q.irq    <= IRQ_RST;
      st_q.settle <= SETTLE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign ZERO_CROSS_LEVEL_SIGNAL_OUT = st_q.lvl;
  assign ZERO_CROSS_IRQ_FLAG_OUT     = st_q.flag;
  assign IRQ_OUT                     = st_q.irq;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);

  sequence raw_rise_held;
    ($rose(RAW_SINK_ACTIVE_IN) && !INVERT_SELECT_IN)
      ##1 (RAW_SINK_ACTIVE_IN && !INVERT_SELECT_IN)[*2];
  endsequence

  sequence raw_fall_held;
    ($fell(RAW_SINK_ACTIVE_IN) && !INVERT_SELECT_IN)
      ##1 (!RAW_SINK_ACTIVE_IN && !INVERT_SELECT_IN)[*2];
  endsequence

  sequence raw_rise_inverted;
    ($rose(RAW_SINK_ACTIVE_IN) && INVERT_SELECT_IN)
      ##1 (RAW_SINK_ACTIVE_IN && INVERT_SELECT_IN)[*2];
  endsequence

  sequence pol_flip;
    primed && $changed(INVERT_SELECT_IN);
  endsequence

  // the cycle right after reset still shows the reset level
  level_plain_a: assert property (
    ($past(RSTN_IN) && !$past(INVERT_SELECT_IN))
      |-> ZERO_CROSS_LEVEL_SIGNAL_OUT == $past(sync_lvl))
    else $error("level does not follow sink state");

  level_invert_a: assert property (
    ($past(RSTN_IN) && $past(INVERT_SELECT_IN))
      |-> ZERO_CROSS_LEVEL_SIGNAL_OUT == !$past(sync_lvl))
    else $error("inverted level wrong");

  sync_path_a: assert property (
    raw_rise_held |=> ZERO_CROSS_LEVEL_SIGNAL_OUT)
    else $error("raw rise not seen three cycles later");

  single_event_a: assert property (
    rise_ev |=> !rise_ev)
    else $error("edge event longer than one cycle");

  edge_sets_a: assert property (
    (fall_ev && FALL_IRQ_ENABLE_IN) |=> ZERO_CROSS_IRQ_FLAG_OUT)
    else $error("falling edge did not set flag");

  adj_rise_a: assert property (
    ($rose(ZERO_CROSS_LEVEL_SIGNAL_OUT) && $past(primed && DETECT_ENABLE_IN
      && RISE_IRQ_ENABLE_IN)) |-> ZERO_CROSS_IRQ_FLAG_OUT)
    else $error("rise of adjusted level missed");

  rise_sets_a: assert property (
    (rise_ev && RISE_IRQ_ENABLE_IN) |=> ZERO_CROSS_IRQ_FLAG_OUT)
    else $error("rising edge did not set flag");

  gated_edge_a: assert property (
    (fall_ev && !FALL_IRQ_ENABLE_IN && !pol_ev && !ZERO_CROSS_IRQ_FLAG_OUT)
      |=> !ZERO_CROSS_IRQ_FLAG_OUT)
    else $error("disabled edge set flag");

  irq_gate_a: assert property (
    IRQ_OUT |-> ZERO_CROSS_IRQ_FLAG_OUT && $past(ZERO_CROSS_IRQ_ENABLE_IN)
      && $past(PERIPHERAL_IRQ_ENABLE_IN) && $past(GLOBAL_IRQ_ENABLE_IN))
    else $error("irq without all enables");

  pol_change_a: assert property (
    pol_flip |=> ZERO_CROSS_IRQ_FLAG_OUT)
    else $error("polarity change did not set flag");

  flag_sticky_a: assert property (
    (ZERO_CROSS_IRQ_FLAG_OUT && !FLAG_CLEAR_IN) |=> ZERO_CROSS_IRQ_FLAG_OUT)
    else $error("flag cleared by hardware");

  set_wins_a: assert property (
    (set_ev && FLAG_CLEAR_IN) |=> ZERO_CROSS_IRQ_FLAG_OUT)
    else $error("clear beat a simultaneous set");

  sync_fall_a: assert property (
    raw_fall_held |=> !ZERO_CROSS_LEVEL_SIGNAL_OUT)
    else $error("raw fall not seen three cycles later");

  sync_invert_a: assert property (
    raw_rise_inverted |=> !ZERO_CROSS_LEVEL_SIGNAL_OUT)
    else $error("inverted raw rise not seen as low level");

  fall_single_a: assert property (
    fall_ev |=> !fall_ev)
    else $error("falling event longer than one cycle");

  settle_quiet_a: assert property (
    (!primed && !ZERO_CROSS_IRQ_FLAG_OUT) |=> !ZERO_CROSS_IRQ_FLAG_OUT)
    else $error("flag set before synchroniser settled");

  det_off_a: assert property (
    (!DETECT_ENABLE_IN && !pol_ev && !ZERO_CROSS_IRQ_FLAG_OUT)
      |=> !ZERO_CROSS_IRQ_FLAG_OUT)
    else $error("disabled detector set flag");

  pol_hold_a: assert property (
    pol_flip ##1 !FLAG_CLEAR_IN |=> ZERO_CROSS_IRQ_FLAG_OUT)
    else $error("polarity flag not held");

  clear_works_a: assert property (
    (FLAG_CLEAR_IN && !set_ev) |=> !ZERO_CROSS_IRQ_FLAG_OUT)
    else $error("software clear ignored");

  irq_follows_a: assert property (
    (ZERO_CROSS_IRQ_FLAG_OUT && !FLAG_CLEAR_IN && ZERO_CROSS_IRQ_ENABLE_IN
      && PERIPHERAL_IRQ_ENABLE_IN && GLOBAL_IRQ_ENABLE_IN) |=> IRQ_OUT)
    else $error("irq missing with flag and all enables");

  irq_drop_a: assert property (
    (!ZERO_CROSS_IRQ_ENABLE_IN || !PERIPHERAL_IRQ_ENABLE_IN || !GLOBAL_IRQ_ENABLE_IN)
      |=> !IRQ_OUT)
    else $error("irq with an enable low");

endmodule : zero_cross_detect_logic

// [rtl/zero_cross_pkg.sv]
package zero_cross_pkg;

  // ----------------------------------------------------------------
  // reset values and settle timing
  // ----------------------------------------------------------------
  localparam logic       LEVEL_RST     = 1'b0;
  localparam logic       INVERT_RST    = 1'b0;
  localparam logic       FLAG_RST      = 1'b0;
  localparam logic       IRQ_RST       = 1'b0;
  localparam int         SETTLE_W      = 2;
  localparam logic [1:0] SETTLE_RST    = 2'h0;
  // cycles after reset before edges count: both sync stages and the level register refilled
  localparam logic [1:0] SETTLE_CYCLES = 2'h3;

endpackage : zero_cross_pkg

// [rtl/zero_cross_sync.sv]
`timescale 1ns/100ps
module zero_cross_sync (
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  input  wire logic async_in,
  output logic      sync_out
);
  import zero_cross_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
  } sync_s;

  sync_s st_q;
  sync_s st_d;

  // ----------------------------------------------------------------
  // two-stage synchroniser; only stage two is ever read outside
  // ----------------------------------------------------------------
  always_comb begin
    st_d    = st_q;
    st_d.s1 = async_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rstn_in) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.s2;

endmodule : zero_cross_sync

// [sim/zero_cross_stage_model.sv]
`timescale 1ns/100ps
module zero_cross_stage_model (
  input  wire logic       clk_in,
  input  wire logic       want_sink_in,
  input  wire logic [1:0] lag_in,
  output logic            sink_active_out
);
  logic [1:0] wait_q;
  initial sink_active_out = 1'b0;
  initial wait_q = 2'h0;
  // slow analogue swing: new state lands lag_in edges late
  always @(posedge clk_in) begin
    if (want_sink_in == sink_active_out) begin
      wait_q <= 2'h0;
    end else if (wait_q == lag_in) begin
      sink_active_out <= want_sink_in;
      wait_q          <= 2'h0;
    end else begin
      wait_q <= wait_q + 2'h1;
    end
  end
endmodule : zero_cross_stage_model

// [sim/zero_cross_detect_logic_tb.sv]
`timescale 1ns/100ps
module zero_cross_detect_logic_tb;
  logic        clk = 1'b0, rstn = 1'b0, want = 1'b0, det = 1'b1, inv = 1'b0;
  logic        rise = 1'b1, fall = 1'b1, clr = 1'b0, raw, lvl_o, flag_o, irq_o;
  logic [2:0]  en = 3'h7;
  logic [1:0]  lag = 2'h0;
  logic [2:0]  st = 3'h0, prev = 3'h0;
  int          cyc = 0, fail_count = 0, comparisons = 0;
  logic [34:0] exp_q[$];
  always #2.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;
  zero_cross_stage_model i_stage (.clk_in(clk), .want_sink_in(want), .lag_in(lag),
    .sink_active_out(raw));
  zero_cross_detect_logic i_dut (.CLK_SYS_IN(clk), .RSTN_IN(rstn), .RAW_SINK_ACTIVE_IN(raw),
    .DETECT_ENABLE_IN(det), .INVERT_SELECT_IN(inv), .RISE_IRQ_ENABLE_IN(rise),
    .FALL_IRQ_ENABLE_IN(fall), .ZERO_CROSS_IRQ_ENABLE_IN(en[0]),
    .PERIPHERAL_IRQ_ENABLE_IN(en[1]), .GLOBAL_IRQ_ENABLE_IN(en[2]), .FLAG_CLEAR_IN(clr),
    .ZERO_CROSS_LEVEL_SIGNAL_OUT(lvl_o), .ZERO_CROSS_IRQ_FLAG_OUT(flag_o), .IRQ_OUT(irq_o));
  // ----------------------------------------------------------------
  // checking: every output change must match the oldest note
  // ----------------------------------------------------------------
  always @(negedge clk) begin
    if (cyc > 0 && {lvl_o, flag_o, irq_o} !== prev) begin
      prev = {lvl_o, flag_o, irq_o};
      comparisons++;
      if (exp_q.size() == 0 || exp_q[0] !== {cyc, prev}) begin
        fail_count++;
        $display("mismatch at %0t: got %h expected %h", $time, {cyc, prev},
                 exp_q.size() ? exp_q[0] : 35'h0);
      end
      if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
  end
  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
  endtask : tick
  task automatic wrap_up();
    if (exp_q.size() != 0) fail_count++;
    if (fail_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up
  // v is {level, flag, irq}; d counts edges from the driving edge's cycle
  task automatic note(int d, logic [2:0] v);
    st = v;
    exp_q.push_back({cyc + d, v});
  endtask : note
  // far side swings with a random lag; level moves three edges after raw
  task automatic swing(logic [2:0] v);
    logic [1:0] l;
    l = 2'($urandom_range(3));
    lag <= l;
    want <= ~want;
    if (v !== st) note(5 + l, v);
    tick(8);
  endtask : swing
  task automatic clear_flag(logic [2:0] v);
    clr <= 1'b1;
    if (v !== st) note(2, v);
    tick(1);
    clr <= 1'b0;
    tick(2);
  endtask : clear_flag
  // ----------------------------------------------------------------
  // stimulus
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(45));
    tick(2);
    rstn <= 1'b1;
    tick(6);
    swing(3'h7);
    clear_flag(3'h4);
    rise <= 1'b0;
    swing(3'h3);
    clear_flag(3'h0);
    swing(3'h4);
    rise <= 1'b1;
    fall <= 1'b0;
    swing(3'h0);
    det <= 1'b0;
    fall <= 1'b1;
    swing(3'h4);
    inv <= 1'b1;
    note(2, 3'h3);
    tick(3);
    for (int i = 0; i < 3; i++) begin
      en[i] <= 1'b0;
      note(2, 3'h2);
      tick(3);
      en[i] <= 1'b1;
      note(2, 3'h3);
      tick(3);
    end
    clear_flag(3'h0);
    det <= 1'b1;
    rise <= 1'b0;
    swing(3'h4);
    swing(3'h3);
    rise <= 1'b1;
    lag <= 2'h0;
    want <= ~want;
    note(5, 3'h7);
    tick(3);
    clr <= 1'b1;
    tick(1);
    clr <= 1'b0;
    tick(4);
    rstn <= 1'b0;
    note(2, 3'h0);
    tick(3);
    rstn <= 1'b1;
    note(2, 3'h4);
    tick(6);
    wrap_up();
  end
  initial begin
    #10000;
    fail_count++;
    wrap_up();
  end
endmodule : zero_cross_detect_logic_tb
